// ### ppoc_map.svh
// Register map, field positions and reset values of the pad configuration block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef PPOC_MAP_SVH
`define PPOC_MAP_SVH

`define PPOC_ADDR_W 12
`define PPOC_DATA_W 8
`define PPOC_NUM_REGS 9
`define PPOC_NUM_OD_PORTS 7

`define PPOC_ADDR_PORT_A_DRAIN 12'hE90
`define PPOC_ADDR_PORT_B_DRAIN 12'hE98
`define PPOC_ADDR_PORT_C_DRAIN 12'hEA0
`define PPOC_ADDR_PORT_D_DRAIN 12'hEA5
`define PPOC_ADDR_PORT_E_DRAIN 12'hEAD
`define PPOC_ADDR_PORT_F_DRAIN 12'hEB2
`define PPOC_ADDR_PORT_G_DRAIN 12'hEBA
`define PPOC_ADDR_PORT_G_PULLUP 12'hEBB
`define PPOC_ADDR_PORT_H_PULLUP 12'hEC0

`define PPOC_IDX_PORT_G_DRAIN 6
`define PPOC_IDX_PORT_G_PULLUP 7
`define PPOC_IDX_PORT_H_PULLUP 8

`define PPOC_MASK_FULL 8'hFF
`define PPOC_MASK_PORT_G 8'hDF
`define PPOC_MASK_PORT_H 8'h0F
`define PPOC_MASK_NONE 8'h00

`define PPOC_RESET_DRAIN 8'h00
`define PPOC_RESET_PULLUP 8'h00

`define PPOC_G_PIN5_BIT 5
`define PPOC_G_PIN5_ONEHOT 8'h20
`define PPOC_H_PINS 4

`endif

// ### ppoc_pad_drv.sv
// Output driver control of one port: push-pull or open-drain per pin.
// Assumes output data and drive enable come from port logic on mclk_i.
`timescale 1ns/1ps
`default_nettype none

module ppoc_pad_drv #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] OD_MASK = '1
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic [WIDTH-1:0] out_data_i,
	input wire logic [WIDTH-1:0] drive_en_i,
	input wire logic [WIDTH-1:0] drain_mode_i,
	output logic [WIDTH-1:0] pad_o,
	output logic [WIDTH-1:0] pad_oe_o
);

	logic [WIDTH-1:0] next_pad;
	logic [WIDTH-1:0] next_pad_oe;

	always_comb begin
		next_pad = '0;
		next_pad_oe = '0;
		for (int i = 0; i < WIDTH; i++) begin
			if (drive_en_i[i]) begin
				if (drain_mode_i[i] && OD_MASK[i]) begin
					// Sink only: drive low, release on high
					next_pad[i] = 1'b0;
					next_pad_oe[i] = !out_data_i[i];
				end else begin
					// Source and sink
					next_pad[i] = out_data_i[i];
					next_pad_oe[i] = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pad_o <= '0;
			pad_oe_o <= '0;
		end else begin
			pad_o <= next_pad;
			pad_oe_o <= next_pad_oe;
		end
	end

endmodule : ppoc_pad_drv

`default_nettype wire

// ### ppoc_pin_model.sv
// Pin model: resolves pin level from pad drive, enable and weak pull-up.
// Assumes one clock; undriven pins without pull-up toggle every cycle.
`timescale 1ns/1ps
`default_nettype none

module ppoc_pin_model (
	input wire logic mclk_i,
	input wire logic [7:0] pad_i,
	input wire logic [7:0] oe_i,
	input wire logic [7:0] pull_i,
	output logic [7:0] pin_o
);
	logic tgl = 1'b0;
	always_ff @(posedge mclk_i) tgl <= ~tgl;
	// Driven, pulled up, or floating
	assign pin_o = (oe_i & pad_i) | (~oe_i & pull_i) | (~oe_i & ~pull_i & {8{tgl}});
endmodule : ppoc_pin_model

`default_nettype wire

// ### ppoc_pkg.sv
// Types shared by the pad configuration block.
// Assumes ppoc_map.svh is on the include path.
`default_nettype none
`include "ppoc_map.svh"

package ppoc_pkg;

	typedef logic [`PPOC_DATA_W-1:0] ppoc_byte_t;
	typedef logic [`PPOC_ADDR_W-1:0] ppoc_addr_t;

	// Strobe qualified by an address match
	function automatic logic ppoc_hit(input ppoc_addr_t addr, input ppoc_addr_t target,
		input logic strobe);
		ppoc_hit = strobe && (addr == target);
	endfunction : ppoc_hit

endpackage : ppoc_pkg

`default_nettype wire

// ### ppoc_reg8.sv
// One byte-wide configuration register with a mask of implemented bits.
// Assumes write strobe and data on the same clock as the register.
`timescale 1ns/1ps
`default_nettype none
`include "ppoc_map.svh"

module ppoc_reg8 #(
	parameter ppoc_pkg::ppoc_byte_t IMPL_MASK = `PPOC_MASK_FULL,
	parameter ppoc_pkg::ppoc_byte_t RESET_VALUE = `PPOC_RESET_DRAIN
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic wr_en_i,
	input wire ppoc_pkg::ppoc_byte_t wdata_i,
	output var ppoc_pkg::ppoc_byte_t value_o
);

	ppoc_pkg::ppoc_byte_t next_value;

	// Store only implemented bits, others stay zero
	always_comb begin
		next_value = value_o;
		if (wr_en_i) begin
			next_value = wdata_i & IMPL_MASK;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			value_o <= RESET_VALUE & IMPL_MASK;
		end else begin
			value_o <= next_value;
		end
	end

endmodule : ppoc_reg8

`default_nettype wire

// ### ppoc_top.sv
// Pad configuration of ports A to H: open-drain select and weak pull-ups.
// Assumes a single-cycle register port and port logic on mclk_i.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ppoc_map.svh"

module ppoc_top (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire ppoc_pkg::ppoc_addr_t addr_i,
	input wire ppoc_pkg::ppoc_byte_t wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output ppoc_pkg::ppoc_byte_t rdata_o,
	input wire logic master_clear_pin_enable_i,
	input wire ppoc_pkg::ppoc_byte_t port_a_data_i,
	input wire ppoc_pkg::ppoc_byte_t port_a_drive_i,
	input wire ppoc_pkg::ppoc_byte_t port_b_data_i,
	input wire ppoc_pkg::ppoc_byte_t port_b_drive_i,
	input wire ppoc_pkg::ppoc_byte_t port_c_data_i,
	input wire ppoc_pkg::ppoc_byte_t port_c_drive_i,
	input wire ppoc_pkg::ppoc_byte_t port_d_data_i,
	input wire ppoc_pkg::ppoc_byte_t port_d_drive_i,
	input wire ppoc_pkg::ppoc_byte_t port_e_data_i,
	input wire ppoc_pkg::ppoc_byte_t port_e_drive_i,
	input wire ppoc_pkg::ppoc_byte_t port_f_data_i,
	input wire ppoc_pkg::ppoc_byte_t port_f_drive_i,
	input wire ppoc_pkg::ppoc_byte_t port_g_data_i,
	input wire ppoc_pkg::ppoc_byte_t port_g_drive_i,
	output ppoc_pkg::ppoc_byte_t port_a_pad_o,
	output ppoc_pkg::ppoc_byte_t port_a_pad_oe_o,
	output ppoc_pkg::ppoc_byte_t port_b_pad_o,
	output ppoc_pkg::ppoc_byte_t port_b_pad_oe_o,
	output ppoc_pkg::ppoc_byte_t port_c_pad_o,
	output ppoc_pkg::ppoc_byte_t port_c_pad_oe_o,
	output ppoc_pkg::ppoc_byte_t port_d_pad_o,
	output ppoc_pkg::ppoc_byte_t port_d_pad_oe_o,
	output ppoc_pkg::ppoc_byte_t port_e_pad_o,
	output ppoc_pkg::ppoc_byte_t port_e_pad_oe_o,
	output ppoc_pkg::ppoc_byte_t port_f_pad_o,
	output ppoc_pkg::ppoc_byte_t port_f_pad_oe_o,
	output ppoc_pkg::ppoc_byte_t port_g_pad_o,
	output ppoc_pkg::ppoc_byte_t port_g_pad_oe_o,
	output ppoc_pkg::ppoc_byte_t port_g_pullup_en_o,
	output logic [`PPOC_H_PINS-1:0] port_h_pullup_en_o
);

	// Register address lookup by index
	function automatic ppoc_pkg::ppoc_addr_t reg_addr(input int idx);
		unique case (idx)
			0: reg_addr = `PPOC_ADDR_PORT_A_DRAIN;
			1: reg_addr = `PPOC_ADDR_PORT_B_DRAIN;
			2: reg_addr = `PPOC_ADDR_PORT_C_DRAIN;
			3: reg_addr = `PPOC_ADDR_PORT_D_DRAIN;
			4: reg_addr = `PPOC_ADDR_PORT_E_DRAIN;
			5: reg_addr = `PPOC_ADDR_PORT_F_DRAIN;
			6: reg_addr = `PPOC_ADDR_PORT_G_DRAIN;
			7: reg_addr = `PPOC_ADDR_PORT_G_PULLUP;
			8: reg_addr = `PPOC_ADDR_PORT_H_PULLUP;
			default: reg_addr = `PPOC_ADDR_PORT_A_DRAIN;
		endcase
	endfunction : reg_addr

	// Implemented bits by index
	function automatic ppoc_pkg::ppoc_byte_t reg_mask(input int idx);
		if (idx == `PPOC_IDX_PORT_G_DRAIN) begin
			reg_mask = `PPOC_MASK_PORT_G;
		end else if (idx == `PPOC_IDX_PORT_H_PULLUP) begin
			reg_mask = `PPOC_MASK_PORT_H;
		end else begin
			reg_mask = `PPOC_MASK_FULL;
		end
	endfunction : reg_mask

	// Reset value by index
	function automatic ppoc_pkg::ppoc_byte_t reg_reset(input int idx);
		if (idx >= `PPOC_IDX_PORT_G_PULLUP) begin
			reg_reset = `PPOC_RESET_PULLUP;
		end else begin
			reg_reset = `PPOC_RESET_DRAIN;
		end
	endfunction : reg_reset

	ppoc_pkg::ppoc_byte_t reg_value [`PPOC_NUM_REGS];
	ppoc_pkg::ppoc_byte_t out_data [`PPOC_NUM_OD_PORTS];
	ppoc_pkg::ppoc_byte_t drive_en [`PPOC_NUM_OD_PORTS];
	ppoc_pkg::ppoc_byte_t pad [`PPOC_NUM_OD_PORTS];
	ppoc_pkg::ppoc_byte_t pad_oe [`PPOC_NUM_OD_PORTS];
	ppoc_pkg::ppoc_byte_t next_rdata;
	ppoc_pkg::ppoc_byte_t next_pullup_g;
	logic [`PPOC_H_PINS-1:0] next_pullup_h;

	// Gather port logic inputs
	assign out_data[0] = port_a_data_i;
	assign out_data[1] = port_b_data_i;
	assign out_data[2] = port_c_data_i;
	assign out_data[3] = port_d_data_i;
	assign out_data[4] = port_e_data_i;
	assign out_data[5] = port_f_data_i;
	assign out_data[6] = port_g_data_i;
	assign drive_en[0] = port_a_drive_i;
	assign drive_en[1] = port_b_drive_i;
	assign drive_en[2] = port_c_drive_i;
	assign drive_en[3] = port_d_drive_i;
	assign drive_en[4] = port_e_drive_i;
	assign drive_en[5] = port_f_drive_i;
	assign drive_en[6] = port_g_drive_i;

	// Configuration registers
	for (genvar r = 0; r < `PPOC_NUM_REGS; r++) begin : g_reg
		ppoc_reg8 #(
			.IMPL_MASK(reg_mask(r)),
			.RESET_VALUE(reg_reset(r))
		) u_reg (
			.mclk_i(mclk_i),
			.rstn_i(rstn_i),
			.wr_en_i(ppoc_pkg::ppoc_hit(addr_i, reg_addr(r), wr_i)),
			.wdata_i(wdata_i),
			.value_o(reg_value[r])
		);
	end

	// Output drivers of ports A to G
	for (genvar p = 0; p < `PPOC_NUM_OD_PORTS; p++) begin : g_pad
		ppoc_pad_drv #(
			.WIDTH(`PPOC_DATA_W),
			.OD_MASK(reg_mask(p))
		) u_pad (
			.mclk_i(mclk_i),
			.rstn_i(rstn_i),
			.out_data_i(out_data[p]),
			.drive_en_i(drive_en[p]),
			.drain_mode_i(reg_value[p]),
			.pad_o(pad[p]),
			.pad_oe_o(pad_oe[p])
		);
	end

	assign port_a_pad_o = pad[0];
	assign port_a_pad_oe_o = pad_oe[0];
	assign port_b_pad_o = pad[1];
	assign port_b_pad_oe_o = pad_oe[1];
	assign port_c_pad_o = pad[2];
	assign port_c_pad_oe_o = pad_oe[2];
	assign port_d_pad_o = pad[3];
	assign port_d_pad_oe_o = pad_oe[3];
	assign port_e_pad_o = pad[4];
	assign port_e_pad_oe_o = pad_oe[4];
	assign port_f_pad_o = pad[5];
	assign port_f_pad_oe_o = pad_oe[5];
	assign port_g_pad_o = pad[6];
	assign port_g_pad_oe_o = pad_oe[6];

	// Read mux, data valid only in the cycle after the strobe
	always_comb begin
		next_rdata = '0;
		for (int r = 0; r < `PPOC_NUM_REGS; r++) begin
			if (ppoc_pkg::ppoc_hit(addr_i, reg_addr(r), rd_i)) begin
				next_rdata = reg_value[r];
			end
		end
	end

	// Pull-up enables toward the pads
	always_comb begin
		next_pullup_g = reg_value[`PPOC_IDX_PORT_G_PULLUP];
		if (master_clear_pin_enable_i) begin
			next_pullup_g = next_pullup_g | `PPOC_G_PIN5_ONEHOT;
		end
		next_pullup_h = reg_value[`PPOC_IDX_PORT_H_PULLUP][`PPOC_H_PINS-1:0];
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= '0;
			port_g_pullup_en_o <= '0;
			port_h_pullup_en_o <= '0;
		end else begin
			rdata_o <= next_rdata;
			port_g_pullup_en_o <= next_pullup_g;
			port_h_pullup_en_o <= next_pullup_h;
		end
	end

endmodule : ppoc_top

`default_nettype wire

// ### ppoc_top_monitor.sv
// Checker of register port timing, pad drive and weak pull-up outputs.
// Assumes binding into ppoc_top, one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "ppoc_map.svh"

module ppoc_top_monitor (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire ppoc_pkg::ppoc_addr_t addr_i,
	input wire ppoc_pkg::ppoc_byte_t wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire ppoc_pkg::ppoc_byte_t rdata_o,
	input wire logic master_clear_pin_enable_i,
	input wire ppoc_pkg::ppoc_byte_t port_g_data_i,
	input wire ppoc_pkg::ppoc_byte_t port_g_drive_i,
	input wire ppoc_pkg::ppoc_byte_t port_g_pad_o,
	input wire ppoc_pkg::ppoc_byte_t port_g_pad_oe_o,
	input wire ppoc_pkg::ppoc_byte_t port_g_pullup_en_o,
	input wire logic [`PPOC_H_PINS-1:0] port_h_pullup_en_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside answer cycle");
	a_unmapped_zero: assert property (rd_i && addr_i == 12'hE91 |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_drain_readback: assert property (wr_i && addr_i == `PPOC_ADDR_PORT_A_DRAIN ##1
		rd_i && addr_i == `PPOC_ADDR_PORT_A_DRAIN |=> rdata_o == $past(wdata_i, 2))
		else $error("drain readback wrong");
	a_g_bit5_zero: assert property (rd_i && addr_i == `PPOC_ADDR_PORT_G_DRAIN |=> !rdata_o[5])
		else $error("port G drain bit 5 set");
	a_g_pullup_wr: assert property (wr_i && addr_i == `PPOC_ADDR_PORT_G_PULLUP ##1
		!(wr_i && addr_i == `PPOC_ADDR_PORT_G_PULLUP) |=> port_g_pullup_en_o ==
		($past(wdata_i, 2) | {2'b00, $past(master_clear_pin_enable_i), 5'b0}))
		else $error("port G pull-up output wrong");
	a_h_pullup_wr: assert property (wr_i && addr_i == `PPOC_ADDR_PORT_H_PULLUP ##1
		!(wr_i && addr_i == `PPOC_ADDR_PORT_H_PULLUP) |=>
		port_h_pullup_en_o == $past(wdata_i[3:0], 2))
		else $error("port H pull-up output wrong");
	a_pin5_forced: assert property ($past(rstn_i) && $past(master_clear_pin_enable_i) |->
		port_g_pullup_en_o[5]) else $error("pin 5 pull-up not forced");
	a_sink_only: assert property ((port_g_pad_o & ~port_g_pad_oe_o) == 8'h00)
		else $error("high level without enable");
	a_pad_follows: assert property (port_g_pad_o ==
		($past(port_g_data_i & port_g_drive_i) & port_g_pad_oe_o)) else $error("pad level wrong");
	a_pin5_push_pull: assert property ($past(rstn_i) |->
		port_g_pad_oe_o[5] == $past(port_g_drive_i[5])) else $error("pin 5 not push-pull");

	c_g_write: cover property (wr_i && addr_i == `PPOC_ADDR_PORT_G_PULLUP);
	c_forced: cover property (master_clear_pin_enable_i && port_g_pullup_en_o[5]);
	c_release: cover property (port_g_drive_i[0] && !port_g_pad_oe_o[0]);
endmodule : ppoc_top_monitor

bind ppoc_top ppoc_top_monitor u_ppoc_top_monitor (.*);

`default_nettype wire

// ### ppoc_top_tb.sv
// Testbench of the pad configuration block.
// Assumes ppoc_pkg, ppoc_top, its checker and the pin model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin err_count++; \
	$display("wrong value %s exp %h got %h", nm, (ex), (gt)); end end

module ppoc_top_tb;
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	ppoc_pkg::ppoc_addr_t addr_i = 12'h000;
	ppoc_pkg::ppoc_byte_t wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic mce = 1'b0;
	ppoc_pkg::ppoc_byte_t dat [7] = '{default: 8'h00};
	ppoc_pkg::ppoc_byte_t drv [7] = '{default: 8'h00};
	wire ppoc_pkg::ppoc_byte_t pad [7];
	wire ppoc_pkg::ppoc_byte_t oe [7];
	wire ppoc_pkg::ppoc_byte_t rdata_o, pu_g, pin_g;
	wire [3:0] pu_h;
	int err_count = 0;
	int checks = 0;
	localparam ppoc_pkg::ppoc_addr_t ADR [9] = '{12'hE90, 12'hE98, 12'hEA0, 12'hEA5, 12'hEAD,
		12'hEB2, 12'hEBA, 12'hEBB, 12'hEC0};
	localparam ppoc_pkg::ppoc_byte_t MSK [9] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'hDF, 8'hFF, 8'h0F};

	ppoc_top u_ppoc_top (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .master_clear_pin_enable_i(mce),
		.port_a_data_i(dat[0]), .port_a_drive_i(drv[0]), .port_b_data_i(dat[1]),
		.port_b_drive_i(drv[1]), .port_c_data_i(dat[2]), .port_c_drive_i(drv[2]),
		.port_d_data_i(dat[3]), .port_d_drive_i(drv[3]), .port_e_data_i(dat[4]),
		.port_e_drive_i(drv[4]), .port_f_data_i(dat[5]), .port_f_drive_i(drv[5]),
		.port_g_data_i(dat[6]), .port_g_drive_i(drv[6]), .port_a_pad_o(pad[0]),
		.port_a_pad_oe_o(oe[0]), .port_b_pad_o(pad[1]), .port_b_pad_oe_o(oe[1]),
		.port_c_pad_o(pad[2]), .port_c_pad_oe_o(oe[2]), .port_d_pad_o(pad[3]),
		.port_d_pad_oe_o(oe[3]), .port_e_pad_o(pad[4]), .port_e_pad_oe_o(oe[4]),
		.port_f_pad_o(pad[5]), .port_f_pad_oe_o(oe[5]), .port_g_pad_o(pad[6]),
		.port_g_pad_oe_o(oe[6]), .port_g_pullup_en_o(pu_g), .port_h_pullup_en_o(pu_h));
	ppoc_pin_model u_ppoc_pin_model (.mclk_i(mclk_i), .pad_i(pad[6]), .oe_i(oe[6]),
		.pull_i(pu_g), .pin_o(pin_g));

	initial forever #12.5 mclk_i = ~mclk_i;

	task automatic bus(input logic w, input logic r, input ppoc_pkg::ppoc_addr_t a,
		input ppoc_pkg::ppoc_byte_t d);
		@(posedge mclk_i);
		wr_i <= w;
		rd_i <= r;
		addr_i <= a;
		wdata_i <= d;
	endtask : bus

	task automatic rd_chk(input int i, input ppoc_pkg::ppoc_byte_t ex);
		bus(1'b0, 1'b1, ADR[i], 8'h00);
		bus(1'b0, 1'b0, 12'h000, 8'h00);
		#1 `CHK("rdata", ex, rdata_o)
	endtask : rd_chk

	task automatic t_regs;
		for (int i = 0; i < 9; i++) rd_chk(i, 8'h00);
		bus(1'b1, 1'b0, 12'hE91, 8'hFF);
		bus(1'b0, 1'b1, 12'hE91, 8'h00);
		bus(1'b0, 1'b0, 12'h000, 8'h00);
		#1 `CHK("unmapped", 8'h00, rdata_o)
		for (int i = 0; i < 9; i++) begin
			bus(1'b1, 1'b0, ADR[i], 8'hFF);
			rd_chk(i, MSK[i]);
			bus(1'b1, 1'b0, ADR[i], 8'h00);
			rd_chk(i, 8'h00);
		end
		$display("test regs done");
	endtask : t_regs

	task automatic t_drive;
		for (int p = 0; p < 7; p++) begin
			bus(1'b1, 1'b0, ADR[p], 8'hFF);
			bus(1'b0, 1'b0, 12'h000, 8'h00);
			dat[p] <= 8'h7A;
			drv[p] <= 8'hF0;
			repeat (2) @(posedge mclk_i);
			#1 `CHK("oe", (p == 6) ? 8'hA0 : 8'h80, oe[p])
			`CHK("pad", (p == 6) ? 8'h20 : 8'h00, pad[p])
			bus(1'b1, 1'b0, ADR[p], 8'h00);
			bus(1'b0, 1'b0, 12'h000, 8'h00);
			@(posedge mclk_i);
			#1 `CHK("oe", 8'hF0, oe[p])
			`CHK("pad", 8'h70, pad[p])
			drv[p] <= 8'h00;
		end
		$display("test drive done");
	endtask : t_drive

	task automatic t_pullup;
		bus(1'b1, 1'b0, ADR[7], 8'h85);
		bus(1'b1, 1'b0, ADR[8], 8'hFF);
		bus(1'b0, 1'b0, 12'h000, 8'h00);
		#1 `CHK("pu_g", 8'h85, pu_g)
		@(posedge mclk_i);
		#1 `CHK("pu_h", 4'hF, pu_h)
		mce <= 1'b1;
		repeat (2) @(posedge mclk_i);
		#1 `CHK("pu_g", 8'hA5, pu_g)
		`CHK("pin_g", 8'hA5, pin_g & 8'hA5)
		rd_chk(7, 8'h85);
		bus(1'b1, 1'b0, ADR[7], 8'h00);
		rd_chk(7, 8'h00);
		#1 `CHK("pu_g", 8'h20, pu_g)
		mce <= 1'b0;
		repeat (2) @(posedge mclk_i);
		#1 `CHK("pu_g", 8'h00, pu_g)
		$display("test pullup done");
	endtask : t_pullup

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test

	initial begin
		#200000;
		err_count++;
		finish_test();
	end

	initial begin
		repeat (5) @(posedge mclk_i);
		rstn_i <= 1'b1;
		t_regs();
		t_drive();
		t_pullup();
		finish_test();
	end
endmodule : ppoc_top_tb

`default_nettype wire
